// file: include/lbt_pkg.sv
// Shared constants and types of the link loopback bit error test engine.
// Assumes a 40 MHz reference clock and a 64 kbit/s link bit rate.
package lbt_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int BIT_PERIOD_NS = 15625;
  localparam int SEC_NS        = 1000000000;
  localparam int BIT_DIV       = BIT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int BITS_PER_SEC  = SEC_NS / BIT_PERIOD_NS;
  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_OCT  = 8'h04;
  localparam logic [7:0] A_ALT  = 8'h08;
  localparam logic [7:0] A_LBP  = 8'h0c;
  localparam logic [7:0] A_DUR  = 8'h10;
  localparam logic [7:0] A_THR  = 8'h14;
  localparam logic [7:0] A_DLY  = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1c;
  localparam logic [7:0] A_ESEC = 8'h20;
  localparam logic [7:0] A_ETOT = 8'h24;
  localparam logic [7:0] A_CAPS = 8'h28;
  // Field positions
  localparam int C_START = 0;
  localparam int C_STOP  = 1;
  localparam int C_PAT   = 2;
  localparam int C_TYPE  = 4;
  localparam int C_ALL   = 6;
  localparam int L_SEL   = 0;
  localparam int L_LAST  = 8;
  localparam int S_ACT   = 0;
  localparam int S_DONE  = 1;
  localparam int S_FAIL  = 2;
  localparam int S_SAT   = 3;
  localparam int S_THR   = 4;
  localparam int S_STOP  = 5;
  localparam int S_REF   = 6;
  localparam int S_LBP   = 8;
  localparam int CAP_SYS = 16;
  // Reset values and limits
  localparam logic [7:0]  OCT_RST  = 8'h32;
  localparam logic [7:0]  ALT_RST  = 8'hff;
  localparam logic [16:0] DUR_RST  = 17'h00001;
  localparam logic [16:0] DUR_MAX  = 17'h15180;
  localparam logic [22:0] THR_RST  = 23'h000038;
  localparam logic [22:0] THR_MAX  = 23'h49d400;
  localparam logic [7:0]  ESEC_SAT = 8'hff;
  localparam logic [7:0]  ALT_HALF = 8'h64;
  localparam logic [7:0]  ALT_LEN  = 8'hc8;
  // Loopback command octets: tag in the top bits, loopback point below
  localparam logic [2:0]  TAG_LOOP = 3'h5;
  localparam logic [2:0]  TAG_CLR  = 3'h6;
  localparam logic [7:0]  CMD_LEN  = 8'h40;
  localparam logic [2:0]  NL_SPAN  = 3'h7;
  // Capacity and AXI response codes
  localparam int SLOTS_DEF     = 1;
  localparam int SYS_MAX_TESTS = 1024;
  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;

  typedef enum logic [1:0] {
    PAT_LONG  = 2'b00,
    PAT_SHORT = 2'b01,
    PAT_OCTET = 2'b10,
    PAT_ALT   = 2'b11
  } lbt_pat_t;

  typedef enum logic [1:0] {
    TT_AUTO = 2'b00,
    TT_MAN  = 2'b01,
    TT_NL   = 2'b10
  } lbt_type_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SETUP = 2'b01,
    ST_RUN   = 2'b10,
    ST_TEAR  = 2'b11
  } lbt_state_t;
endpackage

// file: hdl/lbt_prbs_gen.sv
// Pseudo-random sequence source for the bit error test.
// Assumes the caller steps it once per transmitted data bit.
`timescale 1ns/10ps
module lbt_prbs_gen #(
  parameter int ORDER = 11,
  parameter int TAP   = 9
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  // Control
  input  wire logic clr_i,
  input  wire logic step_i,
  // Sequence
  output logic      bit_o
);
  typedef struct packed {
    logic [ORDER-1:0] sr;
  } lbt_prbs_t;

  lbt_prbs_t q;
  lbt_prbs_t d;

  // All-ones seed; the all-zero lock-up state is never entered
  always_comb begin
    d = q;
    if (clr_i) begin
      d.sr = '1;
    end else if (step_i) begin
      d.sr = {q.sr[ORDER-2:0], q.sr[ORDER-1] ^ q.sr[TAP-1]};
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign bit_o = q.sr[ORDER-1];

  a_lfsr_live: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    q.sr != '0) else $error("sequence register stuck at zero");
endmodule

// file: hdl/lbt_bert_engine.sv
// Bit error test engine for one signalling link port, AXI4-Lite registers.
// Assumes a far-end element loops the transmitted bits back on rx_data_i.
//
// Overview of operation
// - long pseudo-random pattern runs until stopped
// - short pseudo-random pattern runs until stopped
// - non-latching interleaves loopback command with data
// - octet mode repeats octet, default 32 hex
// - alternate 100 value octets, 100 zero octets
// - stream is continuous while test runs
// - each mismatched looped bit counts one error
// - per-second errors hold at 255, test ends
// - automatic latching sends loop-up and clear commands
// - start only on ready port, no traffic
// - up to 32 loopback points per link
// - each loopback point gets its own run
// - concurrent engines per card capped 1/8/64
// - at most 1024 tests system wide
// - run ends when duration expires, default 1s
// - run ends when errors exceed threshold
// - all points in order, abort on failure
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module lbt_bert_engine
  import lbt_pkg::*;
#(
  parameter int TICKS_PER_SEC = lbt_pkg::BITS_PER_SEC,
  parameter int CARD_SLOTS    = lbt_pkg::SLOTS_DEF
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Port condition pins
  input  wire logic        port_powered_i,
  input  wire logic        port_in_service_i,
  input  wire logic        out_of_service_disabled_i,
  // Link
  input  wire logic        rx_data_i,
  output logic             tx_data_o,
  output logic             test_active_o,
  output logic             traffic_allow_o
);
  import lbt_pkg::*;

  localparam logic [9:0]  DIV_LAST = 10'(BIT_DIV - 1);
  localparam logic [16:0] SEC_LAST = 17'(TICKS_PER_SEC - 1);

  typedef struct packed {
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic        awrdy;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [1:0]  pat;
    logic [1:0]  tt;
    logic        all;
    logic [7:0]  oct;
    logic [7:0]  alt;
    logic [4:0]  lsel;
    logic [4:0]  llast;
    logic [16:0] dur;
    logic [22:0] thr;
    logic [5:0]  dly;
    logic        done;
    logic        fail;
    logic        f_sat;
    logic        f_thr;
    logic        stopped;
    logic        refused;
    logic        stop_req;
    lbt_state_t  st;
    logic [4:0]  lbp;
    logic [9:0]  div;
    logic [16:0] scnt;
    logic [16:0] secs;
    logic [7:0]  ocnt;
    logic [2:0]  bph;
    logic [2:0]  slot;
    logic [7:0]  sh;
    logic        cmd;
    logic        tx;
    logic [63:0] hist;
    logic [63:0] vh;
    logic [7:0]  esec;
    logic [22:0] etot;
    logic        act;
    logic        allow;
  } lbt_eng_t;

  localparam lbt_eng_t RST = '{
    oct: OCT_RST, alt: ALT_RST, dur: DUR_RST, thr: THR_RST, st: ST_IDLE,
    tx: 1'b1, allow: 1'b1, default: '0};

  lbt_eng_t q;
  lbt_eng_t d;
  logic tick, sec_end, mism, start, launch, finish, port_ok, cmdf, txbit;
  logic step_l, step_s, pl, ps;
  logic [7:0]  obyte, esec_n;
  logic [22:0] etot_n;
  logic [31:0] wv, rd;

  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] w,
                                      input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = w[8*i +: 8];
      end
    end
    return r;
  endfunction

  lbt_prbs_gen #(.ORDER(11), .TAP(9)) u_long (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .clr_i     (launch),
    .step_i    (step_l),
    .bit_o     (pl)
  );

  lbt_prbs_gen #(.ORDER(9), .TAP(5)) u_short (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .clr_i     (launch),
    .step_i    (step_s),
    .bit_o     (ps)
  );

  always_comb begin
    d = q;
    tick = 1'b0; sec_end = 1'b0; mism = 1'b0; start = 1'b0; launch = 1'b0;
    finish = 1'b0; cmdf = 1'b0; txbit = 1'b1; step_l = 1'b0; step_s = 1'b0;
    obyte = 8'h00; esec_n = q.esec; etot_n = q.etot; wv = 32'h0; rd = 32'h0;
    d.s1 = {rx_data_i, port_powered_i, port_in_service_i, out_of_service_disabled_i};
    d.s2 = q.s1;
    port_ok = &q.s2[2:0];
    // Bit-rate divider, one-cycle enable per link bit
    if (q.div == DIV_LAST) begin
      d.div = '0;
      tick = 1'b1;
    end else begin
      d.div = q.div + 10'h001;
    end
    // Write channel: both address and data must be offered before acceptance
    d.awrdy = s_axi_awvalid_i & s_axi_wvalid_i & ~q.awrdy & ~q.bvalid;
    if (q.bvalid & s_axi_bready_i) d.bvalid = 1'b0;
    if (q.awrdy) begin
      d.bvalid = 1'b1;
      d.bresp = RESP_OK;
      case (s_axi_awaddr_i)
        A_CTRL: begin
          wv = mrg(32'h0, s_axi_wdata_i, s_axi_wstrb_i);
          start = wv[C_START];
          if (wv[C_STOP] && q.st != ST_IDLE) d.stop_req = 1'b1;
          if (q.st == ST_IDLE && s_axi_wstrb_i[0]) begin
            d.pat = wv[C_PAT +: 2];
            d.tt = wv[C_TYPE +: 2];
            d.all = wv[C_ALL];
          end
        end
        A_OCT: begin
          wv = mrg({24'h0, q.oct}, s_axi_wdata_i, s_axi_wstrb_i);
          d.oct = wv[7:0];
        end
        A_ALT: begin
          wv = mrg({24'h0, q.alt}, s_axi_wdata_i, s_axi_wstrb_i);
          d.alt = wv[7:0];
        end
        A_LBP: begin
          wv = mrg({19'h0, q.llast, 3'h0, q.lsel}, s_axi_wdata_i, s_axi_wstrb_i);
          d.lsel = wv[L_SEL +: 5];
          d.llast = wv[L_LAST +: 5];
        end
        A_DUR: begin
          wv = mrg({15'h0, q.dur}, s_axi_wdata_i, s_axi_wstrb_i);
          d.dur = (wv == 32'h0) ? DUR_RST : (wv > {15'h0, DUR_MAX}) ? DUR_MAX : wv[16:0];
        end
        A_THR: begin
          wv = mrg({9'h0, q.thr}, s_axi_wdata_i, s_axi_wstrb_i);
          d.thr = (wv > {9'h0, THR_MAX}) ? THR_MAX : wv[22:0];
        end
        A_DLY: begin
          wv = mrg({26'h0, q.dly}, s_axi_wdata_i, s_axi_wstrb_i);
          d.dly = wv[5:0];
        end
        A_STAT, A_ESEC, A_ETOT, A_CAPS: ;
        default: d.bresp = RESP_ERR;
      endcase
    end
    // Read channel
    d.arrdy = s_axi_arvalid_i & ~q.arrdy & ~q.rvalid;
    if (q.rvalid & s_axi_rready_i) d.rvalid = 1'b0;
    if (q.arrdy) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OK;
      case (s_axi_araddr_i)
        A_CTRL: begin
          rd[C_PAT +: 2] = q.pat;
          rd[C_TYPE +: 2] = q.tt;
          rd[C_ALL] = q.all;
        end
        A_OCT: rd[7:0] = q.oct;
        A_ALT: rd[7:0] = q.alt;
        A_LBP: begin
          rd[L_SEL +: 5] = q.lsel;
          rd[L_LAST +: 5] = q.llast;
        end
        A_DUR: rd[16:0] = q.dur;
        A_THR: rd[22:0] = q.thr;
        A_DLY: rd[5:0] = q.dly;
        A_STAT: begin
          rd[S_ACT] = q.act;
          rd[S_DONE] = q.done;
          rd[S_FAIL] = q.fail;
          rd[S_SAT] = q.f_sat;
          rd[S_THR] = q.f_thr;
          rd[S_STOP] = q.stopped;
          rd[S_REF] = q.refused;
          rd[S_LBP +: 5] = q.lbp;
        end
        A_ESEC: rd[7:0] = q.esec;
        A_ETOT: rd[22:0] = q.etot;
        // One engine here; the card and system caps are enforced by software
        A_CAPS: rd = {16'(SYS_MAX_TESTS), 16'(CARD_SLOTS)};
        default: d.rresp = RESP_ERR;
      endcase
      d.rdata = rd;
    end
    // Bit source: an octet is chosen at bit phase zero and shifted out MSB first
    if (tick && q.st != ST_IDLE) begin
      if (q.bph == 3'h0) begin
        case (q.st)
          ST_SETUP: begin
            obyte = {TAG_LOOP, q.lbp};
            cmdf = 1'b1;
            d.ocnt = q.ocnt + 8'h01;
          end
          ST_TEAR: begin
            obyte = {TAG_CLR, q.lbp};
            cmdf = 1'b1;
            d.ocnt = q.ocnt + 8'h01;
          end
          default: begin
            if (q.tt == TT_NL && q.slot == NL_SPAN) begin
              obyte = {TAG_LOOP, q.lbp};
              cmdf = 1'b1;
              d.slot = 3'h0;
            end else begin
              if (q.tt == TT_NL) d.slot = q.slot + 3'h1;
              if (q.pat == PAT_OCTET) begin
                obyte = q.oct;
              end else if (q.pat == PAT_ALT) begin
                obyte = (q.ocnt < ALT_HALF) ? q.alt : 8'h00;
                d.ocnt = (q.ocnt == ALT_LEN - 8'h01) ? 8'h00 : q.ocnt + 8'h01;
              end
            end
          end
        endcase
      end else begin
        obyte = q.sh;
        cmdf = q.cmd;
      end
      step_l = q.st == ST_RUN && !cmdf && q.pat == PAT_LONG;
      step_s = q.st == ST_RUN && !cmdf && q.pat == PAT_SHORT;
      txbit = step_l ? pl : step_s ? ps : obyte[7];
      d.sh = {obyte[6:0], 1'b0};
      d.cmd = cmdf;
      d.bph = q.bph + 3'h1;
      d.tx = txbit;
      d.hist = {q.hist[62:0], txbit};
      d.vh = {q.vh[62:0], q.st == ST_RUN && !cmdf};
      // Looped bit is held against the bit sent dly+1 link bits earlier
      mism = q.vh[q.dly] & (q.s2[3] != q.hist[q.dly]);
    end
    // Test sequencing
    case (q.st)
      ST_IDLE: begin
        if (start) begin
          // Judged on the settings of the starting write itself, not the old ones
          if (!port_ok || d.tt == 2'b11 || (d.tt == TT_NL && d.pat[1])) begin
            d.refused = 1'b1;
          end else begin
            d.refused = 1'b0;
            d.done = 1'b0;
            d.fail = 1'b0;
            d.f_sat = 1'b0;
            d.f_thr = 1'b0;
            d.stopped = 1'b0;
            d.stop_req = 1'b0;
            d.lbp = d.all ? 5'h00 : q.lsel;
            launch = 1'b1;
          end
        end
      end
      ST_SETUP, ST_TEAR: begin
        if (tick && q.bph == 3'h7 && q.ocnt == CMD_LEN) begin
          if (q.st == ST_SETUP) begin
            d.st = ST_RUN;
            d.ocnt = 8'h00;
            d.bph = 3'h0;
          end else begin
            finish = 1'b1;
          end
        end
      end
      default: begin
        if (tick) begin
          sec_end = q.scnt == SEC_LAST;
          d.scnt = sec_end ? 17'h0 : q.scnt + 17'h1;
          esec_n = (mism && q.esec != ESEC_SAT) ? q.esec + 8'h01 : q.esec;
          etot_n = (mism && q.etot != '1) ? q.etot + 23'h1 : q.etot;
          d.esec = esec_n;
          d.etot = etot_n;
          if (sec_end) d.secs = q.secs + 17'h1;
          if (esec_n == ESEC_SAT) begin
            d.fail = 1'b1;
            d.f_sat = 1'b1;
            finish = 1'b1;
          end else if (etot_n > q.thr) begin
            d.fail = 1'b1;
            d.f_thr = 1'b1;
            finish = 1'b1;
          end else if (q.stop_req) begin
            d.stopped = 1'b1;
            finish = 1'b1;
          end else if (sec_end && q.secs + 17'h1 >= q.dur) begin
            finish = 1'b1;
          end else if (sec_end) begin
            d.esec = 8'h00;
          end
        end
      end
    endcase
    // End of a run: automatic latching first clears the loopback point
    if (finish) begin
      if (q.st == ST_RUN && q.tt == TT_AUTO) begin
        d.st = ST_TEAR;
        d.ocnt = 8'h00;
        d.bph = 3'h0;
      end else if (q.all && !d.fail && !d.stopped && q.lbp != q.llast) begin
        d.lbp = q.lbp + 5'h01;
        launch = 1'b1;
      end else begin
        d.st = ST_IDLE;
        d.done = 1'b1;
        d.tx = 1'b1;
      end
    end
    if (launch) begin
      // Manual latching relies on a loopback set by hand, so no commands go out
      d.st = (d.tt == TT_AUTO) ? ST_SETUP : ST_RUN;
      d.cmd = 1'b0;
      d.ocnt = 8'h00;
      d.bph = 3'h0;
      d.slot = 3'h0;
      d.scnt = 17'h0;
      d.secs = 17'h0;
      d.esec = 8'h00;
      d.etot = 23'h0;
      d.vh = 64'h0;
    end
    d.act = d.st != ST_IDLE;
    d.allow = d.st == ST_IDLE;
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready_o = q.awrdy;
  assign s_axi_wready_o  = q.awrdy;
  assign s_axi_bresp_o   = q.bresp;
  assign s_axi_bvalid_o  = q.bvalid;
  assign s_axi_arready_o = q.arrdy;
  assign s_axi_rdata_o   = q.rdata;
  assign s_axi_rresp_o   = q.rresp;
  assign s_axi_rvalid_o  = q.rvalid;
  assign tx_data_o       = q.tx;
  assign test_active_o   = q.act;
  assign traffic_allow_o = q.allow;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_sat_ends_run: assert property (
    (tick && q.st == ST_RUN && mism && q.esec == 8'hfe) |=>
      (q.st != ST_RUN && q.f_sat && q.esec == ESEC_SAT))
    else $error("saturated error count did not end run");
  a_sat_no_wrap: assert property (
    (q.esec == ESEC_SAT && !launch) |=> q.esec == ESEC_SAT)
    else $error("per-second error count wrapped");
  a_err_counted: assert property (
    (mism && q.st == ST_RUN && q.esec < 8'hfe && !sec_end) |=>
      (q.esec == $past(q.esec) + 8'h01 && q.etot == $past(q.etot) + 23'h1))
    else $error("mismatch not counted");
  a_thr_ends_run: assert property (
    (q.st == ST_RUN) |-> q.etot <= q.thr)
    else $error("run continued past error threshold");
  a_dur_bound: assert property (
    (q.st == ST_RUN) |-> q.secs < q.dur)
    else $error("run continued past its duration");
  a_refuse_start: assert property (
    (q.st == ST_IDLE && start && !port_ok) |=> (q.st == ST_IDLE && q.refused))
    else $error("start accepted on unready port");
  a_no_traffic: assert property (
    (q.st != ST_IDLE) |-> (!traffic_allow_o && test_active_o))
    else $error("traffic allowed during test");
  a_nl_cmd_slot: assert property (
    (tick && q.st == ST_RUN && q.tt == TT_NL && q.bph == 3'h0 && q.slot == NL_SPAN)
      |=> q.cmd)
    else $error("loopback command not interleaved");
  a_man_no_cmd: assert property (
    (q.tt == TT_MAN && q.st != ST_IDLE) |-> (!q.cmd && q.st == ST_RUN))
    else $error("command sent in manual latching test");
  a_alt_range: assert property (
    (q.st == ST_RUN && q.pat == PAT_ALT) |-> q.ocnt < ALT_LEN)
    else $error("alternating block counter out of range");

  c_pass_done: cover property (q.st == ST_RUN ##1 (q.done && !q.fail));
  c_sat_fail: cover property ($rose(q.f_sat));
  c_next_lbp: cover property (q.all && q.lbp != 5'h00 && q.st == ST_RUN);
  c_refused: cover property ($rose(q.refused));
endmodule

// file: test/lbt_loop_model.sv
// Far-end loopback element model for the link test bench.
// Assumes the bench opens and closes the loop by hand, as a manual latch would.
`timescale 1ns/10ps
module lbt_loop_model (
  // Link
  input  wire logic tx_i,
  input  wire logic loop_i,
  output logic      rx_o
);
  // An open loop returns the inverse, so stale data can never pass as good
  // Stands for an element already optioned for latching loopback
  assign rx_o = loop_i ? tx_i : ~tx_i;
endmodule

// file: test/lbt_tb.sv
// Self-checking bench for the link bit error test engine.
// Assumes a 40 MHz clock, a bit tick every 625 clocks and a looping far end.
`timescale 1ns/10ps
module tb;
  import lbt_pkg::*;
  localparam int TPS = 16;
  logic        ref_clk_i = 0;
  logic        sys_rst_i = 1;
  logic [7:0]  awaddr = 0;
  logic [7:0]  araddr = 0;
  logic [31:0] wdata = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        pwr = 1, insvc = 1, oosd = 1, loop_en = 1;
  logic        awready, wready, bvalid, arready, rvalid, tx, rx, active, allow;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  oct;
  logic [4:0]  pt;
  logic [33:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [1:0]  rsp_q[$];
  logic        bitq[$];
  int          errors = 0, checked = 0, cyc = 0;
  integer      seed = 32'he73d9b0a;

  lbt_bert_engine #(.TICKS_PER_SEC(TPS)) dut_u (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .port_powered_i(pwr),
    .port_in_service_i(insvc), .out_of_service_disabled_i(oosd), .rx_data_i(rx),
    .tx_data_o(tx), .test_active_o(active), .traffic_allow_o(allow));

  lbt_loop_model far_u (.tx_i(tx), .loop_i(loop_en), .rx_o(rx));

  initial forever #12.5 ref_clk_i = ~ref_clk_i;

  task automatic chk(string n, logic [33:0] e, logic [33:0] s);
    checked++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic print_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = RESP_OK);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    rsp_q.push_back(r);
    fork
      begin
        do @(posedge ref_clk_i); while (!awready);
        awvalid <= 0;
      end
      begin
        do @(posedge ref_clk_i); while (!wready);
        wvalid <= 0;
      end
    join
    do @(posedge ref_clk_i); while (!bvalid);
    bready <= 0;
    @(posedge ref_clk_i);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m = '1,
                    logic [1:0] r = RESP_OK);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    exp_q.push_back({r, e & m});
    msk_q.push_back(m);
    do @(posedge ref_clk_i); while (!arready);
    arvalid <= 0;
    do @(posedge ref_clk_i); while (!rvalid);
    rready <= 0;
    @(posedge ref_clk_i);
  endtask

  // Start mid-bit so the first sampled bit is the first bit sent
  task automatic run(logic [31:0] ctrl);
    bitq.delete();
    while (cyc % 625 != 400) @(posedge ref_clk_i);
    wr(A_CTRL, ctrl);
    chk("active_allow", 34'h2, {32'h0, active, allow});
  endtask

  task automatic wait_end;
    while (active !== 1'b0) @(posedge ref_clk_i);
  endtask

  function automatic logic prbs(int n, bit lng);
    logic [10:0] r;
    logic        o;
    r = '1;
    for (int i = 0; i <= n; i++) begin
      o = lng ? r[10] : r[8];
      r = lng ? {r[9:0], r[10] ^ r[8]} : {r[9:0], r[8] ^ r[4]};
    end
    return o;
  endfunction

  always @(posedge ref_clk_i) begin
    if (!sys_rst_i)
      cyc <= cyc + 1;
    if (cyc % 625 == 312 && active === 1'b1)
      bitq.push_back(tx);
    if (bvalid === 1'b1 && bready)
      chk("bresp", 34'(rsp_q.pop_front()), 34'(bresp));
    if (rvalid === 1'b1 && rready)
      chk("rdata", exp_q.pop_front(), {rresp, rdata & msk_q.pop_front()});
  end

  initial begin
    // About 64400 cycles of tests, with margin
    repeat (95000) @(posedge ref_clk_i);
    errors++;
    print_verdict();
  end

  initial begin
    oct = 8'($random(seed));
    pt = 5'($random(seed));
    repeat (12) @(posedge ref_clk_i);
    sys_rst_i <= 0;
    @(posedge ref_clk_i);
    rd(A_OCT, 32'h32);
    rd(A_ALT, 32'hff);
    rd(A_THR, 32'd56);
    rd(A_CAPS, 32'h04000001);
    rd(8'h80, 32'h0, '1, RESP_ERR);
    wr(8'h80, 32'h1, RESP_ERR);
    wr(A_DUR, 32'h0);
    rd(A_DUR, 32'h1);
    wr(A_THR, 32'h7fffff);
    rd(A_THR, 32'd4838400);
    wr(A_THR, 32'd3);
    insvc <= 0;
    repeat (4) @(posedge ref_clk_i);
    wr(A_CTRL, 32'h11);
    @(posedge ref_clk_i);
    chk("idle_allow", 34'h1, {32'h0, active, allow});
    rd(A_STAT, 32'h40, 32'h41);
    insvc <= 1;
    repeat (4) @(posedge ref_clk_i);
    // Manual latch, short sequence, clean loop, one second
    run(32'h15);
    wait_end();
    // The tick that ends the run sends no bit, so TPS ticks carry TPS-1 bits
    chk("nbits", 34'(TPS - 1), 34'(bitq.size()));
    for (int i = 0; i < TPS - 1; i++)
      chk("short_bit", 34'(prbs(i, 0)), 34'(bitq[i]));
    rd(A_ETOT, 32'h0);
    rd(A_STAT, 32'h2, 32'h7);
    // Repeated octet with a random value
    wr(A_OCT, {24'h0, oct});
    run(32'h19);
    wait_end();
    for (int i = 0; i < TPS - 1; i++)
      chk("octet_bit", 34'(oct[7 - i % 8]), 34'(bitq[i]));
    // Open loop, alternating pattern: every compared bit is wrong until the threshold trips
    loop_en <= 0;
    run(32'h1d);
    wait_end();
    loop_en <= 1;
    for (int i = 0; i < 4; i++)
      chk("alt_bit", 34'(ALT_RST[7 - i]), 34'(bitq[i]));
    rd(A_ETOT, 32'd4);
    rd(A_ESEC, 32'd4);
    rd(A_STAT, 32'h14, 32'h15);
    // Non-latching long sequence at a random point, stopped by software
    wr(A_LBP, {27'h0, pt});
    wr(A_DUR, 32'd100);
    run(32'h21);
    while (bitq.size() < 64) @(posedge ref_clk_i);
    chk("still_active", 34'h1, 34'(active));
    wr(A_CTRL, 32'h2);
    wait_end();
    for (int i = 0; i < 56; i++)
      chk("long_bit", 34'(prbs(i, 1)), 34'(bitq[i]));
    for (int i = 0; i < 8; i++)
      chk("cmd_bit", 34'(({TAG_LOOP, pt} >> (7 - i)) & 1), 34'(bitq[56 + i]));
    rd(A_STAT, 32'h20, 32'h25);
    rd(A_ETOT, 32'h0);
    print_verdict();
  end
endmodule
